// >>> hw/bck_core.sv
// Batch controller core: keys, relays, counters, menu and display selection
`timescale 1ns/1ps
module bck_core
  import bck_pkg::*;
#(
  parameter int CNT_W   = BCK_CNT_W,
  parameter int RATE_W  = BCK_RATE_W,
  parameter bit HAS_LIN = 1'b0
)(
  input  wire logic              i_clock,
  input  wire logic              i_arst_n,
  input  wire bck_key_s          i_key,
  input  wire logic              i_remote_start,
  input  wire logic              i_remote_stop,
  input  wire logic              i_flow_pulse,
  input  wire logic              i_rate_valid,
  input  wire logic [RATE_W-1:0] i_rate_sample,
  output logic                   o_final_relay,
  output logic                   o_warn_relay,
  output logic                   o_batch_done,
  output logic                   o_run_mode,
  output logic [CNT_W-1:0]       o_batch_count,
  output logic [CNT_W-1:0]       o_grand_total,
  output logic [RATE_W-1:0]      o_rate,
  output bck_disp_s              o_disp
);

  initial begin
    if (CNT_W != 32) $error("bck_core: CNT_W must be 32");
  end

  // All checks below run on the one clock and stand still in reset
  default clocking bck_cb @(posedge i_clock);
  endclocking
  default disable iff (!i_arst_n);

  // ****************************************************************
  // Remote inputs
  // ****************************************************************
  logic rstart_rise, rstop_rise, rstop_level;

  // Remote start synchroniser and edge detector
  bck_edge_sync u_sync_start (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_pin(i_remote_start),
                              .o_level(), .o_rise(rstart_rise));

  // Remote stop/reset synchroniser; its level also inhibits starts
  bck_edge_sync u_sync_stop (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_pin(i_remote_stop),
                             .o_level(rstop_level), .o_rise(rstop_rise));

  // Flow pulse synchroniser
  logic flow_rise;
  bck_edge_sync u_sync_flow (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_pin(i_flow_pulse),
                             .o_level(), .o_rise(flow_rise));

  // ****************************************************************
  // Key decode
  // ****************************************************************
  typedef enum logic [1:0] {BCK_RUN, BCK_SELECT, BCK_STEP} bck_mode_e;

  bck_mode_e mode;
  logic      running;
  logic      show_rate;
  logic      show_grand;
  logic [2:0] item;
  logic      cleared;
  logic [31:0] entry;
  logic [2:0]  entry_dp;
  logic [3:0]  entry_digits;
  logic [31:0] preset;
  logic [31:0] warn;
  logic        count_to_preset;
  logic [6:0]  weight;

  function automatic logic key_is(input bck_key_s k, input bck_key_e c);
    key_is = k.valid && (k.code == c);
  endfunction : key_is

  logic k_start, k_stop, k_rate, k_menu, k_accept, k_clear, k_digit;
  assign k_start  = key_is(i_key, BCK_KEY_START);
  assign k_stop   = key_is(i_key, BCK_KEY_STOP);
  assign k_rate   = key_is(i_key, BCK_KEY_RATE);
  assign k_menu   = key_is(i_key, BCK_KEY_MENU);
  assign k_accept = key_is(i_key, BCK_KEY_ACCEPT);
  assign k_clear  = key_is(i_key, BCK_KEY_CLEAR);
  assign k_digit  = i_key.valid && (i_key.code <= BCK_KEY_D9);

  logic run_view_count;
  assign run_view_count = (mode == BCK_RUN) && !show_rate && !show_grand;

  // ****************************************************************
  // Batch control
  // ****************************************************************
  logic start_req, stop_req, count_reset, reached_preset, reached_warn;

  // Starts are inhibited while the remote stop is held high
  assign start_req   = (k_start || rstart_rise) && !rstop_level;
  assign stop_req    = k_stop || (rstop_rise && running && !o_batch_done);
  assign count_reset = rstop_rise && (!running || o_batch_done);
  assign reached_preset = (o_batch_count + 32'h1 >= preset) && flow_rise;
  assign reached_warn   = (o_batch_count + 32'h1 >= warn) && flow_rise;

  // Run state and completion flag; completion wins over a clear in the same cycle
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      running      <= 1'b0;
      o_batch_done <= 1'b0;
    end else begin
      if (count_reset || (k_clear && run_view_count)) begin
        o_batch_done <= 1'b0;
      end
      if (stop_req) begin
        running <= 1'b0;
      end else if (running && reached_preset) begin
        running      <= 1'b0;
        o_batch_done <= 1'b1;
      end else if (start_req && !o_batch_done) begin
        running <= 1'b1;
      end
    end
  end

  // Relays; warning relay drops early at the warning count
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_final_relay <= 1'b0;
      o_warn_relay  <= 1'b0;
    end else begin
      if (stop_req || (running && reached_preset)) begin
        o_final_relay <= 1'b0;
        o_warn_relay  <= 1'b0;
      end else if (start_req && !running && !o_batch_done) begin
        o_final_relay <= 1'b1;
        o_warn_relay  <= (o_batch_count < warn);
      end else if (running && reached_warn) begin
        o_warn_relay  <= 1'b0;
      end
    end
  end

  // Batch counter counts only while running, resumes after stop
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_batch_count <= '0;
    end else if (count_reset || (k_clear && run_view_count)) begin
      o_batch_count <= count_to_preset ? preset : '0;
    end else if (running && flow_rise) begin
      o_batch_count <= o_batch_count + 32'h1;
    end
  end

  // Grand total counts every pulse whatever the relays do; a pulse in the clear cycle is kept
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_grand_total <= '0;
    end else if (k_clear && mode == BCK_RUN && show_grand) begin
      o_grand_total <= flow_rise ? 32'h1 : 32'h0;
    end else if (flow_rise) begin
      o_grand_total <= o_grand_total + 32'h1;
    end
  end

  // ****************************************************************
  // Run mode display toggles
  // ****************************************************************
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      show_rate  <= 1'b0;
      show_grand <= 1'b0;
    end else if (mode == BCK_RUN) begin
      if (k_rate && !show_grand) begin
        show_rate <= ~show_rate;
      end else if (k_accept && !show_rate) begin
        show_grand <= ~show_grand;
      end
    end
  end

  // ****************************************************************
  // Menu sequencing
  // ****************************************************************
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode <= BCK_RUN;
      item <= BCK_ITEM_PRESET;
    end else begin
      case (mode)
        BCK_RUN: begin
          if (k_menu) begin
            mode <= BCK_SELECT;
            item <= BCK_ITEM_PRESET;
          end
        end
        BCK_SELECT: begin
          if (k_menu) begin
            item <= (item == BCK_ITEM_LAST) ? BCK_ITEM_PRESET : item + 3'h1;
          end else if (k_accept) begin
            mode <= BCK_STEP;
          end
        end
        BCK_STEP: begin
          if (k_accept) begin
            if (item == BCK_ITEM_LAST) begin
              mode <= BCK_RUN;
            end else begin
              item <= item + 3'h1;
            end
          end
        end
        default: mode <= BCK_RUN;
      endcase
    end
  end

  // ****************************************************************
  // Value entry
  // ****************************************************************
  logic [31:0] cur_value;
  always_comb begin
    if (item == BCK_ITEM_PRESET) begin
      cur_value = preset;
    end else if (item == BCK_ITEM_WARN) begin
      cur_value = warn;
    end else if (item == BCK_ITEM_CMODE) begin
      cur_value = {31'h0, count_to_preset};
    end else begin
      cur_value = {25'h0, weight};
    end
  end

  // Entry field: cleared first, then digits shift in
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cleared      <= 1'b0;
      entry        <= '0;
      entry_dp     <= BCK_DP_NONE;
      entry_digits <= 4'h0;
    end else if (mode != BCK_STEP || k_accept) begin
      cleared      <= 1'b0;
      entry        <= '0;
      entry_dp     <= BCK_DP_NONE;
      entry_digits <= 4'h0;
    end else if (k_clear) begin
      cleared      <= 1'b1;
      entry        <= '0;
      entry_dp     <= BCK_DP_NONE;
      entry_digits <= 4'h0;
    end else if (cleared && k_digit && entry_digits < 4'(BCK_ENTRY_DIG)) begin
      entry        <= 32'(entry * 32'ha + 32'(i_key.code));
      entry_digits <= entry_digits + 4'h1;
      if (entry_dp != BCK_DP_NONE) begin
        entry_dp <= entry_dp + 3'h1;
      end
    end else if (cleared && k_menu && entry_digits != 4'h0) begin
      entry_dp <= 3'h1;
    end
  end

  // Stored parameters; accept without a clear keeps the old value
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      preset          <= BCK_PRESET_RST;
      warn            <= BCK_WARN_RST;
      count_to_preset <= 1'b0;
      weight          <= BCK_WEIGHT_RST;
    end else if (mode == BCK_STEP && k_accept && cleared) begin
      if (item == BCK_ITEM_PRESET) begin
        preset <= entry;
      end else if (item == BCK_ITEM_WARN) begin
        warn <= entry;
      end else if (item == BCK_ITEM_CMODE) begin
        count_to_preset <= entry[0];
      end else if (entry <= 32'(BCK_WEIGHT_MAX)) begin
        weight <= entry[6:0];
      end
    end
  end

  // ****************************************************************
  // Rate averaging
  // ****************************************************************
  bck_rate_avg #(.RATE_W(RATE_W), .HAS_AVG(!HAS_LIN)) u_avg (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .i_sample_valid(i_rate_valid), .i_sample(i_rate_sample),
    .i_weight(weight), .o_rate(o_rate), .o_valid());

  // ****************************************************************
  // Display descriptor
  // ****************************************************************
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_disp <= '0;
    end else begin
      o_disp.stopped_msg <= rstop_level;
      o_disp.menu_item   <= item;
      o_disp.dp_pos      <= entry_dp;
      o_disp.rate_mark   <= (mode == BCK_RUN) && show_rate;
      if (mode != BCK_RUN) begin
        o_disp.sel   <= BCK_SHOW_PROG;
        o_disp.flash <= 1'b1;
        o_disp.value <= cleared ? entry : cur_value;
      end else if (show_grand) begin
        o_disp.sel   <= BCK_SHOW_GRAND;
        o_disp.flash <= 1'b1;
        o_disp.value <= o_grand_total;
      end else if (show_rate) begin
        o_disp.sel   <= BCK_SHOW_RATE;
        o_disp.flash <= rstop_level;
        o_disp.value <= 32'(o_rate);
      end else begin
        o_disp.sel   <= BCK_SHOW_COUNT;
        o_disp.flash <= rstop_level;
        o_disp.value <= o_batch_count;
      end
    end
  end

  assign o_run_mode = (mode == BCK_RUN);

  // ****************************************************************
  // Checks
  // ****************************************************************
  start_relays_a: assert property (k_start && !rstop_level && !running && !o_batch_done && !k_stop
    |=> o_final_relay) else $error("start did not energize final relay");
  stop_relays_a: assert property (k_stop |=> !o_final_relay && !o_warn_relay && !running)
    else $error("stop did not drop relays");
  inhibit_start_a: assert property (rstop_level && !running |=> !running)
    else $error("start accepted while remote stop held");
  done_relays_a: assert property ($rose(o_batch_done) |-> !o_final_relay && !o_warn_relay)
    else $error("relays active at completion");
  grand_clear_a: assert property (k_clear && mode == BCK_RUN && show_grand
    |=> o_grand_total == 32'($past(flow_rise))) else $error("grand total not cleared");
  menu_enter_a: assert property (k_menu && mode == BCK_RUN
    |=> mode == BCK_SELECT ##1 o_disp.sel == BCK_SHOW_PROG) else $error("menu key did not enter programming");
  unedited_keep_a: assert property (mode == BCK_STEP && k_accept && !cleared
    |=> $stable(preset) && $stable(warn) && $stable(weight)) else $error("unedited accept changed a value");
  remote_reset_a: assert property (count_reset && !count_to_preset |=> o_batch_count == 32'h0)
    else $error("remote reset did not clear count");
  grand_counts_a: assert property (flow_rise && !k_clear
    |=> o_grand_total == $past(o_grand_total) + 32'h1) else $error("grand total missed a pulse");

endmodule : bck_core

// >>> hw/bck_edge_sync.sv
// Two flop synchroniser with rising edge detector for a remote contact input
`timescale 1ns/1ps
module bck_edge_sync
  import bck_pkg::*;
(
  input  wire logic i_clock,
  input  wire logic i_arst_n,
  input  wire logic i_pin,
  output logic      o_level,
  output logic      o_rise
);

  logic meta;
  logic sync;
  logic prev;

  // Synchroniser chain, first stage is read by the second only
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= i_pin;
      sync <= meta;
      prev <= sync;
    end
  end

  assign o_level = sync;
  assign o_rise  = sync & ~prev;

endmodule : bck_edge_sync

// >>> hw/bck_pkg.sv
// Package of shared constants and types for the batch control keypad core
package bck_pkg;

  // ****************************************************************
  // Key codes
  // ****************************************************************
  typedef enum logic [3:0] {
    BCK_KEY_D0, BCK_KEY_D1, BCK_KEY_D2, BCK_KEY_D3, BCK_KEY_D4,
    BCK_KEY_D5, BCK_KEY_D6, BCK_KEY_D7, BCK_KEY_D8, BCK_KEY_D9,
    BCK_KEY_START, BCK_KEY_STOP, BCK_KEY_RATE, BCK_KEY_MENU,
    BCK_KEY_ACCEPT, BCK_KEY_CLEAR
  } bck_key_e;

  // ****************************************************************
  // Display selection
  // ****************************************************************
  typedef enum logic [1:0] {
    BCK_SHOW_COUNT, BCK_SHOW_RATE, BCK_SHOW_GRAND, BCK_SHOW_PROG
  } bck_show_e;

  // Keypad strobe with its code
  typedef struct packed {
    logic     valid;
    bck_key_e code;
  } bck_key_s;

  // Display descriptor
  typedef struct packed {
    bck_show_e  sel;
    logic       rate_mark;
    logic       flash;
    logic       stopped_msg;
    logic [2:0] menu_item;
    logic [2:0] dp_pos;
    logic [31:0] value;
  } bck_disp_s;

  // ****************************************************************
  // Widths, limits and reset values
  // ****************************************************************
  localparam int          BCK_CNT_W     = 32;
  localparam int          BCK_RATE_W    = 24;
  localparam int          BCK_ENTRY_DIG = 8;
  localparam logic [6:0]  BCK_WEIGHT_MAX = 7'h63;
  localparam logic [6:0]  BCK_WEIGHT_RST = 7'h00;
  localparam logic [31:0] BCK_PRESET_RST = 32'h0000_0000;
  localparam logic [31:0] BCK_WARN_RST   = 32'h0000_0000;
  localparam logic [2:0]  BCK_DP_NONE    = 3'h0;
  localparam logic [2:0]  BCK_ITEM_LAST  = 3'h3;
  localparam logic [2:0]  BCK_ITEM_PRESET = 3'h0;
  localparam logic [2:0]  BCK_ITEM_WARN   = 3'h1;
  localparam logic [2:0]  BCK_ITEM_CMODE  = 3'h2;
  localparam logic [2:0]  BCK_ITEM_WEIGHT = 3'h3;

endpackage : bck_pkg

// >>> hw/bck_rate_avg.sv
// Weighted moving average of rate samples
`timescale 1ns/1ps
module bck_rate_avg
  import bck_pkg::*;
#(
  parameter int  RATE_W   = BCK_RATE_W,
  parameter bit  HAS_AVG  = 1'b1
)(
  input  wire logic              i_clock,
  input  wire logic              i_arst_n,
  input  wire logic              i_sample_valid,
  input  wire logic [RATE_W-1:0] i_sample,
  input  wire logic [6:0]        i_weight,
  output logic      [RATE_W-1:0] o_rate,
  output logic                   o_valid
);

  initial begin
    if (RATE_W < 8 || RATE_W > 48) $error("bck_rate_avg: RATE_W out of range");
  end

  localparam int PW = RATE_W + 8;

  logic [PW-1:0]     num;
  logic [RATE_W-1:0] next_rate;

  // New rate is (old times W plus sample) over W plus one
  always_comb begin
    num = PW'(o_rate) * PW'(i_weight) + PW'(i_sample);
    if (!HAS_AVG || i_weight == 7'h00) begin
      next_rate = i_sample;
    end else begin
      next_rate = RATE_W'(num / PW'({1'b0, i_weight} + 8'h01));
    end
  end

  // Averaged rate register
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rate  <= '0;
      o_valid <= 1'b0;
    end else begin
      o_valid <= i_sample_valid;
      if (i_sample_valid) begin
        o_rate <= next_rate;
      end
    end
  end

  zero_weight_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    i_sample_valid && i_weight == 7'h00 |=> o_rate == $past(i_sample))
    else $error("zero weight did not pass sample through");

endmodule : bck_rate_avg

// >>> sim/batch_control_keypad_bench.sv
// Self-checking bench for the batch control core
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; $display("Error %s exp %0h got %0h", n, e, g); end end
module batch_control_keypad_bench
  import bck_pkg::*;
;
  logic        i_clock = 1'b0;
  logic        i_arst_n;
  logic        rate_valid;
  logic [23:0] rate_sample;
  bck_key_s    key;
  logic        rstart, rstop, flow, final_relay, warn_relay, done, run_mode;
  logic [31:0] count, grand;
  logic [23:0] rate;
  bck_disp_s   disp;
  int          fails = 0;
  int          compares = 0;
  bck_key_e    prog[12] = '{BCK_KEY_MENU, BCK_KEY_ACCEPT, BCK_KEY_CLEAR, BCK_KEY_D5, BCK_KEY_MENU, BCK_KEY_ACCEPT,
                            BCK_KEY_CLEAR, BCK_KEY_D3, BCK_KEY_ACCEPT, BCK_KEY_ACCEPT, BCK_KEY_CLEAR, BCK_KEY_D1};
  bck_key_e    cmode[10] = '{BCK_KEY_MENU, BCK_KEY_MENU, BCK_KEY_MENU, BCK_KEY_ACCEPT, BCK_KEY_CLEAR, BCK_KEY_D1,
                             BCK_KEY_ACCEPT, BCK_KEY_CLEAR, BCK_KEY_D1, BCK_KEY_ACCEPT};

  // Clock at 125 MHz
  always #4 i_clock = ~i_clock;

  bck_panel_model i_panel (.i_clock(i_clock), .o_key(key), .o_remote_start(rstart), .o_remote_stop(rstop),
                           .o_flow_pulse(flow));
  bck_core i_dut (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_key(key), .i_remote_start(rstart),
                  .i_remote_stop(rstop), .i_flow_pulse(flow), .i_rate_valid(rate_valid), .i_rate_sample(rate_sample),
                  .o_final_relay(final_relay), .o_warn_relay(warn_relay), .o_batch_done(done), .o_run_mode(run_mode),
                  .o_batch_count(count), .o_grand_total(grand), .o_rate(rate), .o_disp(disp));

  // Let updates land, then sample clear of the edge
  task automatic settle(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : settle

  task automatic press(input bck_key_e c);
    i_panel.press(c);
    settle(2);
  endtask : press

  task automatic sample(input logic [23:0] v);
    @(posedge i_clock) begin rate_valid <= 1'b1; rate_sample <= v; end
    @(posedge i_clock) rate_valid <= 1'b0;
    settle(3);
  endtask : sample

  task automatic finish_test();
    if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  initial begin
    #200us;
    fails++;
    finish_test();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    i_arst_n    = 1'b0;
    rate_valid  = 1'b0;
    rate_sample = '0;
    repeat (4) @(posedge i_clock);
    i_arst_n <= 1'b1;
    settle(1);
    `CHK("run_mode", 1'b1, run_mode)
    // Weight is zero after reset, so the sample passes straight through
    sample(24'h64);
    `CHK("rate", 24'h64, rate)
    // Preset 5, warning 3, count mode skipped, weight 1
    foreach (prog[i]) begin
      press(prog[i]);
      if (i == 0) `CHK("run_mode", 1'b0, run_mode)
      if (i == 2) `CHK("entry", 32'h0, disp.value)
      if (i == 4) `CHK("dp_pos", 3'h1, disp.dp_pos)
    end
    press(BCK_KEY_ACCEPT);
    `CHK("run_mode", 1'b1, run_mode)
    press(BCK_KEY_START);
    `CHK("final", 1'b1, final_relay)
    `CHK("warn", 1'b1, warn_relay)
    i_panel.pulses(3);
    settle(5);
    `CHK("count", 32'h3, count)
    `CHK("warn", 1'b0, warn_relay)
    press(BCK_KEY_STOP);
    `CHK("final", 1'b0, final_relay)
    press(BCK_KEY_START);
    `CHK("final", 1'b1, final_relay)
    i_panel.pulses(2);
    settle(5);
    `CHK("count", 32'h5, count)
    `CHK("done", 1'b1, done)
    `CHK("final", 1'b0, final_relay)
    press(BCK_KEY_CLEAR);
    `CHK("count", 32'h0, count)
    `CHK("grand", 32'h5, grand)
    press(BCK_KEY_ACCEPT);
    `CHK("sel", BCK_SHOW_GRAND, disp.sel)
    `CHK("flash", 1'b1, disp.flash)
    press(BCK_KEY_CLEAR);
    `CHK("grand", 32'h0, grand)
    press(BCK_KEY_ACCEPT);
    `CHK("sel", BCK_SHOW_COUNT, disp.sel)
    // Weight 1: 100 and 100 give 100, then 100 and 200 give 150
    sample(24'h64);
    sample(24'hc8);
    `CHK("rate", 24'h96, rate)
    press(BCK_KEY_RATE);
    `CHK("sel", BCK_SHOW_RATE, disp.sel)
    `CHK("mark", 1'b1, disp.rate_mark)
    press(BCK_KEY_RATE);
    // Remote stop held high blocks starts
    i_panel.stop_level(1'b1);
    settle(6);
    `CHK("stopped", 1'b1, disp.stopped_msg)
    `CHK("flash", 1'b1, disp.flash)
    press(BCK_KEY_START);
    `CHK("final", 1'b0, final_relay)
    i_panel.stop_level(1'b0);
    i_panel.start_pulse();
    settle(6);
    `CHK("final", 1'b1, final_relay)
    i_panel.pulses(1);
    i_panel.stop_level(1'b1);
    i_panel.stop_level(1'b0);
    settle(6);
    `CHK("final", 1'b0, final_relay)
    `CHK("count", 32'h1, count)
    i_panel.stop_level(1'b1);
    i_panel.stop_level(1'b0);
    settle(6);
    `CHK("count", 32'h0, count)
    // Count mode set to load preset; weight shown, cleared and keyed again
    foreach (cmode[i]) begin
      press(cmode[i]);
      if (i == 2) `CHK("item", 3'h2, disp.menu_item)
      if (i == 6) `CHK("weight", 32'h1, disp.value)
      if (i == 7) `CHK("entry", 32'h0, disp.value)
    end
    `CHK("run_mode", 1'b1, run_mode)
    press(BCK_KEY_CLEAR);
    `CHK("count", 32'h5, count)
    finish_test();
  end
endmodule : batch_control_keypad_bench

// >>> sim/bck_panel_model.sv
// Operator keypad and remote contact model facing the batch control core
`timescale 1ns/1ps
module bck_panel_model
  import bck_pkg::*;
(
  input  wire logic i_clock,
  output bck_key_s  o_key,
  output logic      o_remote_start,
  output logic      o_remote_stop,
  output logic      o_flow_pulse
);
  // ****************************************************************
  // Idle levels from time zero
  // ****************************************************************
  initial begin
    o_key          = '0;
    o_remote_start = 1'b0;
    o_remote_stop  = 1'b0;
    o_flow_pulse   = 1'b0;
  end

  // One cycle key strobe per press
  task automatic press(input bck_key_e c);
    @(posedge i_clock) o_key <= '{valid: 1'b1, code: c};
    @(posedge i_clock) o_key <= '0;
  endtask : press

  // Count pulses, two cycles high and two low so each edge is seen
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge i_clock) o_flow_pulse <= 1'b1;
      @(posedge i_clock);
      @(posedge i_clock) o_flow_pulse <= 1'b0;
      @(posedge i_clock);
    end
  endtask : pulses

  // Remote start contact closure
  task automatic start_pulse();
    @(posedge i_clock) o_remote_start <= 1'b1;
    repeat (2) @(posedge i_clock);
    o_remote_start <= 1'b0;
  endtask : start_pulse

  // Remote stop contact held at a level
  task automatic stop_level(input logic v);
    @(posedge i_clock) o_remote_stop <= v;
  endtask : stop_level
endmodule : bck_panel_model
